/* dat_pkg.sv */
// Shared constants and types for the digital input acquisition timing engine.
// Assumes a single 125 MHz reference clock; widths are defaults, except LINE_W in dat_fifo_model and FILT_CNT_W in dat_engine.
package dat_pkg;
  localparam int FUNC_PIN_N = 8;
  localparam int LINE_W = 8;
  localparam int DIV_W = 16;
  localparam int CNT_W = 24;
  localparam int FILT_W = 8;
  localparam int FILT_CNT_W = 12;
  // Filter step and clock period in picoseconds
  localparam int FILT_STEP_PS = 25000;
  localparam int CLK_PERIOD_PS = 8000;
  // Output pin routing choices
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_STROBE = 2'h1;
  localparam logic [1:0] ROUTE_BEGIN = 2'h2;
  localparam logic [1:0] ROUTE_REF = 2'h3;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARM = 5'h02,
    ST_DELAY = 5'h04,
    ST_RUN = 5'h08,
    ST_POST = 5'h10
  } dat_state_t;
endpackage : dat_pkg

/* dat_debounce.sv */
// Per-module debounce filter for the digital input lines.
// Lines arrive from pins; they are synchronised here before any use.
`timescale 1ns/1ps
module dat_debounce import dat_pkg::*; #(
  parameter int W = LINE_W,
  parameter int CW = FILT_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic en,
  input wire logic [CW-1:0] half_cyc,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] smp;
    logic [W-1:0] q;
    logic [CW-1:0] cnt;
  } dat_deb_t;

  dat_deb_t st_r;
  dat_deb_t st_nxt;
  logic tick;
  logic [W-1:0] q_bit;

  assign tick = (st_r.cnt == '0);

  // One shared strobe for all lines keeps the module on one setting
  for (genvar i = 0; i < W; i++) begin : g_line
    assign q_bit[i] = !en ? st_r.s2[i] :
      (tick && (st_r.s2[i] == st_r.smp[i])) ? st_r.s2[i] : st_r.q[i];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.q = q_bit;
    if (tick) begin
      st_nxt.cnt = half_cyc - 1'b1;
      st_nxt.smp = st_r.s2;
    end else begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

  filt_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(st_r.q) && $past(en)) |-> $past(tick))
    else $error("Filtered line moved between strobes");
  filt_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && en && tick && (st_r.s2 != st_r.smp)) |=> st_r.q == $past(st_r.q))
    else $error("Single-sample pulse passed the filter");
  filt_pass_c: cover property (@(posedge clk) disable iff (!rst_n)
    ce && en && tick && (st_r.q != st_r.s2) && (st_r.s2 == st_r.smp));
endmodule : dat_debounce

/* dat_engine.sv */
// Timing and trigger engine for hardware-timed digital input acquisition.
// Assumes pins and routed signals are asynchronous; software controls are
// on REF_CLK. The acquisition FIFO sits outside and reports FIFO_FULL.
`timescale 1ns/1ps
module dat_engine import dat_pkg::*; #(
  parameter int PN = FUNC_PIN_N,
  parameter int LW = LINE_W,
  parameter int DW = DIV_W,
  parameter int CW = CNT_W,
  parameter int FW = FILT_W
) (
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Pins and routed signals
  input wire logic [PN-1:0] FUNC_PIN_IN,
  input wire logic COUNTER_OUT,
  input wire logic THRESH_EVT,
  input wire logic EXT_TIMEBASE,
  input wire logic EXT_STROBE,
  input wire logic [LW-1:0] DI_LINES,
  // Strobe configuration
  input wire logic CFG_TB_EXT,
  input wire logic CFG_STROBE_EXT,
  input wire logic CFG_STROBE_FALL,
  input wire logic [DW-1:0] CFG_DIV,
  input wire logic [CW-1:0] CFG_START_DELAY,
  // Trigger configuration
  input wire logic CFG_BEGIN_EN,
  input wire logic [$clog2(PN+2)-1:0] CFG_BEGIN_SRC,
  input wire logic CFG_BEGIN_FALL,
  input wire logic CFG_REF_EN,
  input wire logic [$clog2(PN+2)-1:0] CFG_REF_SRC,
  input wire logic CFG_REF_FALL,
  input wire logic CFG_HOLD_EN,
  input wire logic [$clog2(PN+2)-1:0] CFG_HOLD_SRC,
  input wire logic CFG_HOLD_LOW,
  input wire logic [1:0] CFG_ROUTE,
  // Acquisition configuration
  input wire logic CFG_FINITE,
  input wire logic [CW-1:0] CFG_SAMPLE_COUNT,
  input wire logic [CW-1:0] CFG_BUF_SIZE,
  input wire logic [CW-1:0] CFG_PRETRIG,
  input wire logic CFG_HW_TIMED,
  input wire logic CFG_FILT_EN,
  input wire logic [FW-1:0] CFG_FILT_STEPS,
  // Software commands
  input wire logic SW_START,
  input wire logic SW_STOP,
  input wire logic OVF_ACK,
  // FIFO side
  input wire logic FIFO_FULL,
  output logic FIFO_WR,
  output logic FIFO_DROP,
  output logic [LW-1:0] FIFO_DATA,
  // Status and pin output
  output logic FUNC_PIN_OUT,
  output logic BUSY,
  output logic DONE,
  output logic OVF_ERR
);
  localparam int SN = PN + 2;
  localparam int SW = $clog2(SN);
  localparam int VW = SN + 2;
  localparam logic [SW-1:0] THR_IDX = SW'(PN + 1);
  localparam int TB_IDX = SN;
  localparam int STB_IDX = SN + 1;
  localparam int HALF_DIV = 2 * CLK_PERIOD_PS;

  typedef struct packed {
    dat_state_t st;
    logic [VW-1:0] s1;
    logic [VW-1:0] s2;
    logic [VW-1:0] p;
    logic [DW-1:0] div_cnt;
    logic int_lvl;
    logic stb_prev;
    logic [CW-1:0] dly_cnt;
    logic [CW-1:0] smp_cnt;
    logic [CW-1:0] buf_cnt;
    logic [CW-1:0] post_cnt;
    logic begin_pls;
    logic ref_pls;
    logic ovf;
    logic wr;
    logic drop;
    logic [LW-1:0] data;
    logic fpin;
    logic busy;
    logic done;
  } dat_eng_t;

  dat_eng_t st_r;
  dat_eng_t st_nxt;

  logic [SN-1:0] src_now;
  logic [SN-1:0] src_old;
  logic begin_hit;
  logic ref_hit;
  logic hold_act;
  logic tb_tick;
  logic stb_lvl;
  logic stb_edge;
  logic samp;
  logic wrap;
  logic armed;
  logic [CW-1:0] post_goal;
  logic [LW-1:0] deb_out;
  logic filt_on;
  logic [31:0] half_full;
  logic [FILT_CNT_W-1:0] half_cyc;

  function automatic logic edge_of(input logic lvl, input logic old, input logic fall);
    edge_of = fall ? (old & ~lvl) : (lvl & ~old);
  endfunction : edge_of

  // Filter strobe at half the minimum width: a pulse needs two samples
  assign half_full = (32'(CFG_FILT_STEPS) * FILT_STEP_PS) / HALF_DIV;
  assign half_cyc = (half_full == 0) ? FILT_CNT_W'(1) : half_full[FILT_CNT_W-1:0];
  assign filt_on = CFG_FILT_EN & CFG_HW_TIMED;

  dat_debounce #(
    .W(LW),
    .CW(FILT_CNT_W)
  ) u_filter (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .en(filt_on),
    .half_cyc(half_cyc),
    .din(DI_LINES),
    .dout(deb_out)
  );

  assign src_now = st_r.s2[SN-1:0];
  assign src_old = st_r.p[SN-1:0];

  // Threshold event always starts on its rising edge
  assign begin_hit = (CFG_BEGIN_SRC == THR_IDX) ?
    edge_of(src_now[CFG_BEGIN_SRC], src_old[CFG_BEGIN_SRC], 1'b0) :
    edge_of(src_now[CFG_BEGIN_SRC], src_old[CFG_BEGIN_SRC], CFG_BEGIN_FALL);
  assign ref_hit = edge_of(src_now[CFG_REF_SRC], src_old[CFG_REF_SRC],
    CFG_REF_FALL);
  // Level only: no edge term here
  assign hold_act = CFG_HOLD_EN & (src_now[CFG_HOLD_SRC] ^ CFG_HOLD_LOW);

  assign tb_tick = CFG_TB_EXT ?
    (st_r.s2[TB_IDX] & ~st_r.p[TB_IDX]) : 1'b1;
  assign stb_lvl = CFG_STROBE_EXT ? st_r.s2[STB_IDX] : st_r.int_lvl;
  assign stb_edge = edge_of(stb_lvl, st_r.stb_prev, CFG_STROBE_FALL);
  assign samp = ((st_r.st == ST_RUN) || (st_r.st == ST_POST)) && stb_edge;
  assign wrap = CFG_REF_EN && (st_r.st == ST_RUN) &&
    (st_r.buf_cnt >= CFG_BUF_SIZE);
  assign armed = (st_r.smp_cnt >= CFG_PRETRIG);
  assign post_goal = CFG_BUF_SIZE - CFG_PRETRIG;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {EXT_STROBE, EXT_TIMEBASE, THRESH_EVT, COUNTER_OUT, FUNC_PIN_IN};
    st_nxt.s2 = st_r.s1;
    st_nxt.p = st_r.s2;
    st_nxt.stb_prev = stb_lvl;
    st_nxt.begin_pls = 1'b0;
    st_nxt.ref_pls = 1'b0;
    st_nxt.wr = 1'b0;
    st_nxt.drop = 1'b0;
    st_nxt.done = 1'b0;

    // Internal strobe: one tick high per divider wrap, frozen on hold
    if (((st_r.st == ST_RUN) || (st_r.st == ST_POST)) && !hold_act && tb_tick) begin
      st_nxt.int_lvl = (st_r.div_cnt == '0);
      st_nxt.div_cnt = (st_r.div_cnt == '0) ? CFG_DIV - 1'b1 : st_r.div_cnt - 1'b1;
    end

    case (st_r.st)
      ST_IDLE: begin
        if (SW_START) begin
          st_nxt.smp_cnt = '0;
          st_nxt.buf_cnt = '0;
          st_nxt.post_cnt = '0;
          st_nxt.busy = 1'b1;
          if (CFG_BEGIN_EN) begin
            st_nxt.st = ST_ARM;
          end else begin
            st_nxt.begin_pls = 1'b1;
            st_nxt.st = ST_DELAY;
          end
        end
      end
      ST_ARM: begin
        if (begin_hit) begin
          st_nxt.begin_pls = 1'b1;
          st_nxt.st = ST_DELAY;
        end
      end
      default: begin
      end
    endcase

    // Delay applies only to the internally made strobe
    if ((st_nxt.st == ST_DELAY) && (st_r.st != ST_DELAY)) begin
      st_nxt.dly_cnt = CFG_START_DELAY;
      st_nxt.div_cnt = '0;
      st_nxt.int_lvl = 1'b0;
    end
    if (st_r.st == ST_DELAY) begin
      if (CFG_STROBE_EXT || (st_r.dly_cnt == '0)) begin
        st_nxt.st = ST_RUN;
      end else begin
        st_nxt.dly_cnt = st_r.dly_cnt - 1'b1;
      end
    end

    if (samp) begin
      if (FIFO_FULL && !wrap) begin
        st_nxt.ovf = 1'b1;
      end else begin
        st_nxt.wr = 1'b1;
        st_nxt.data = deb_out;
        st_nxt.drop = wrap;
        st_nxt.smp_cnt = st_r.smp_cnt + 1'b1;
        if (!wrap) begin
          st_nxt.buf_cnt = st_r.buf_cnt + 1'b1;
        end
        if (st_r.st == ST_POST) begin
          st_nxt.post_cnt = st_r.post_cnt + 1'b1;
          if (st_r.post_cnt + 1'b1 >= post_goal) begin
            st_nxt.st = ST_IDLE;
          end
        end else if (CFG_FINITE && !CFG_REF_EN &&
                     (st_r.smp_cnt + 1'b1 == CFG_SAMPLE_COUNT)) begin
          st_nxt.st = ST_IDLE;
        end
      end
    end

    // Reference only counts once the pretrigger part is in
    if ((st_r.st == ST_RUN) && CFG_FINITE && CFG_REF_EN && ref_hit && armed) begin
      st_nxt.ref_pls = 1'b1;
      st_nxt.st = (post_goal == '0) ? ST_IDLE : ST_POST;
    end

    if (SW_STOP && (st_r.st != ST_IDLE)) begin
      st_nxt.st = ST_IDLE;
    end
    if ((st_r.st != ST_IDLE) && (st_nxt.st == ST_IDLE)) begin
      st_nxt.busy = 1'b0;
      st_nxt.done = 1'b1;
    end

    // Acknowledge or restart clears; a new overflow in that cycle wins
    if ((OVF_ACK || (SW_START && (st_r.st == ST_IDLE))) &&
        !(samp && FIFO_FULL && !wrap)) begin
      st_nxt.ovf = 1'b0;
    end

    case (CFG_ROUTE)
      ROUTE_STROBE: st_nxt.fpin = ~stb_lvl;
      ROUTE_BEGIN: st_nxt.fpin = st_nxt.begin_pls;
      ROUTE_REF: st_nxt.fpin = st_nxt.ref_pls;
      default: st_nxt.fpin = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.st <= ST_IDLE;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign FIFO_WR = st_r.wr;
  assign FIFO_DROP = st_r.drop;
  assign FIFO_DATA = st_r.data;
  assign FUNC_PIN_OUT = st_r.fpin;
  assign BUSY = st_r.busy;
  assign DONE = st_r.done;
  assign OVF_ERR = st_r.ovf;

  ovf_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CE && samp && FIFO_FULL && !wrap) |=> OVF_ERR && !FIFO_WR)
    else $error("Strobe into full FIFO did not flag overflow");
  ovf_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (OVF_ERR && !OVF_ACK && !SW_START) |=> OVF_ERR)
    else $error("Overflow dropped without acknowledge");
  one_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CE && samp && !(FIFO_FULL && !wrap)) |=> FIFO_WR && (FIFO_DATA == $past(deb_out)))
    else $error("Strobe did not store one reading");
  edge_only_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (FIFO_WR && $past(CE)) |-> $past(samp))
    else $error("Write without an active strobe edge");
  pin_inv_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CE && (CFG_ROUTE == ROUTE_STROBE)) |=> FUNC_PIN_OUT == !$past(stb_lvl))
    else $error("Routed strobe not inverted");
  drop_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    FIFO_DROP |-> FIFO_WR && $past(CFG_REF_EN) && ($past(st_r.st) == ST_RUN))
    else $error("Oldest sample dropped outside pretrigger wrap");
  ref_early_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CE && (st_r.st == ST_RUN) && ref_hit && !armed && !samp) |=> st_r.st != ST_POST)
    else $error("Reference taken before pretrigger count");
  hold_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CE && hold_act && (st_r.st == ST_RUN)) |=> $stable(st_r.int_lvl) && $stable(st_r.div_cnt))
    else $error("Internal strobe ran during hold");
  fin_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CE && CFG_FINITE && !CFG_REF_EN && samp && !FIFO_FULL && !SW_STOP &&
     (st_r.smp_cnt + 1'b1 == CFG_SAMPLE_COUNT)) |=> (st_r.st == ST_IDLE) && DONE)
    else $error("Finite acquisition did not stop at count");

  post_entry_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    CE && (st_r.st == ST_RUN) ##1 (st_r.st == ST_POST));
  ovf_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) CE && !OVF_ERR ##1 OVF_ERR);
  wrap_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) FIFO_DROP);
  fin_done_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) DONE && CFG_FINITE);
endmodule : dat_engine

/* dat_fifo_model.sv */
// Behavioural acquisition FIFO on the engine's write side.
// Assumes one REF_CLK domain; the bench sets depth and clears it per scenario.
`timescale 1ns/1ps
module dat_fifo_model import dat_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic clr,
  input wire logic [7:0] depth,
  // Engine side
  input wire logic wr,
  input wire logic drop,
  input wire logic [LINE_W-1:0] data,
  output logic full,
  // Bookkeeping
  output int wr_cnt,
  output int drop_cnt,
  output logic [LINE_W-1:0] last_data
);
  int level;
  assign full = (level >= int'(depth));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 0;
      wr_cnt <= 0;
      drop_cnt <= 0;
      last_data <= '0;
    end else if (clr) begin
      level <= 0;
      wr_cnt <= 0;
      drop_cnt <= 0;
    end else if (wr) begin
      // A push into a full FIFO without drop is lost, as in the real part
      wr_cnt <= wr_cnt + 1;
      last_data <= data;
      if (drop) begin
        drop_cnt <= drop_cnt + 1;
      end else if (!full) begin
        level <= level + 1;
      end
    end
  end
endmodule : dat_fifo_model

/* di_acquisition_timing_engine_tb.sv */
// Self-checking bench for the acquisition timing engine.
// Assumes dat_engine and dat_fifo_model; all inputs change 1 ns after the edge.
`timescale 1ns/1ps
module di_acquisition_timing_engine_tb import dat_pkg::*; ;
  localparam int SW = $clog2(FUNC_PIN_N+2);
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [FUNC_PIN_N-1:0] FUNC_PIN_IN = '0;
  logic tbase = 1'b0;
  logic tb_ext;
  logic thr = 1'b0;
  logic EXT_STROBE = 1'b0;
  logic [LINE_W-1:0] DI_LINES = 8'ha5;
  logic s_ext, s_fall, b_en, b_fall, r_en, r_fall, h_en, h_low, fin, filt;
  logic [SW-1:0] b_src, r_src, h_src;
  logic [1:0] route;
  logic [DIV_W-1:0] div;
  logic [CNT_W-1:0] n_smp, n_buf, n_pre, dly;
  logic start, stop, ack, clr, full, wr, drop, pin_out, busy, done, ovf;
  logic [7:0] depth;
  logic [LINE_W-1:0] wdata, last;
  int wr_cnt, drop_cnt, err_total, cmp_count, k, n0, seen;

  always #4 REF_CLK = ~REF_CLK;

  dat_engine i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'b1), .FUNC_PIN_IN(FUNC_PIN_IN),
    .COUNTER_OUT(1'b0), .THRESH_EVT(thr), .EXT_TIMEBASE(tbase), .EXT_STROBE(EXT_STROBE),
    .DI_LINES(DI_LINES), .CFG_TB_EXT(tb_ext), .CFG_STROBE_EXT(s_ext),
    .CFG_STROBE_FALL(s_fall), .CFG_DIV(div), .CFG_START_DELAY(dly),
    .CFG_BEGIN_EN(b_en), .CFG_BEGIN_SRC(b_src), .CFG_BEGIN_FALL(b_fall),
    .CFG_REF_EN(r_en), .CFG_REF_SRC(r_src), .CFG_REF_FALL(r_fall), .CFG_HOLD_EN(h_en),
    .CFG_HOLD_SRC(h_src), .CFG_HOLD_LOW(h_low), .CFG_ROUTE(route), .CFG_FINITE(fin),
    .CFG_SAMPLE_COUNT(n_smp), .CFG_BUF_SIZE(n_buf), .CFG_PRETRIG(n_pre),
    .CFG_HW_TIMED(filt), .CFG_FILT_EN(filt), .CFG_FILT_STEPS(8'h04), .SW_START(start),
    .SW_STOP(stop), .OVF_ACK(ack), .FIFO_FULL(full), .FIFO_WR(wr), .FIFO_DROP(drop),
    .FIFO_DATA(wdata), .FUNC_PIN_OUT(pin_out), .BUSY(busy), .DONE(done), .OVF_ERR(ovf));

  dat_fifo_model i_fifo (.clk(REF_CLK), .rst_n(RST_N), .clr(clr), .depth(depth),
    .wr(wr), .drop(drop), .data(wdata), .full(full), .wr_cnt(wr_cnt),
    .drop_cnt(drop_cnt), .last_data(last));

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge REF_CLK);
      #1;
    end
  endtask : tick

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse

  task automatic wait_wr();
    k = 0;
    do begin
      tick();
      k++;
    end while (wr !== 1'b1 && k < 400);
  endtask : wait_wr

  task automatic wait_done();
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      tick();
      k++;
    end
    check(done === 1'b1, "no done pulse");
    tick();
  endtask : wait_done

  task automatic defaults();
    {s_ext, s_fall, b_en, b_fall, r_en, r_fall, h_en, h_low, fin, filt} = '0;
    {b_src, r_src, h_src, route, start, stop, ack} = '0;
    tb_ext = 1'b0;
    div = 16'h0004;
    n_smp = 24'h000064;
    n_buf = 24'h000005;
    n_pre = 24'h000003;
    dly = '0;
    depth = 8'hc8;
    clr = 1'b1;
    tick();
    clr = 1'b0;
  endtask : defaults

  task automatic t_finite();
    defaults();
    fin = 1'b1;
    filt = 1'b1;
    n_smp = 24'h000003;
    dly = 24'h000010;
    pulse(start);
    tick(10);
    check(wr_cnt == 0, "write inside start delay");
    wait_wr();
    wait_wr();
    check(k == 4, "strobe spacing");
    wait_done();
    check(wr_cnt == 3, "finite count");
    check(last === 8'ha5, "sample data");
    check(busy === 1'b0, "busy after done");
  endtask : t_finite

  task automatic t_overflow();
    defaults();
    depth = 8'h02;
    pulse(start);
    tick(40);
    check(wr_cnt == 2 && ovf === 1'b1, "overflow flag");
    pulse(stop);
    wait_done();
    tick(10);
    check(ovf === 1'b1, "overflow kept");
    pulse(ack);
    tick();
    check(ovf === 1'b0, "overflow ack");
  endtask : t_overflow

  task automatic t_begin();
    for (int f = 0; f < 3; f++) begin
      defaults();
      FUNC_PIN_IN[2] = f[0];
      thr = (f == 2);
      b_en = 1'b1;
      b_src = (f == 2) ? SW'(FUNC_PIN_N + 1) : SW'(2);
      b_fall = (f != 0);
      fin = 1'b1;
      n_smp = 24'h000002;
      route = ROUTE_BEGIN;
      tick(5);
      pulse(start);
      // Falling threshold edge must not start, even with falling selected
      thr = 1'b0;
      tick(30);
      check(wr_cnt == 0 && busy === 1'b1, "armed, no samples");
      if (f == 2) begin
        thr = 1'b1;
      end else begin
        FUNC_PIN_IN[2] = ~f[0];
      end
      n0 = 0;
      repeat (10) begin
        tick();
        if (pin_out === 1'b1) n0 = 1;
      end
      check(n0 == 1, "begin pulse on pin");
      wait_done();
      check(wr_cnt == 2, "samples after begin edge");
    end
  endtask : t_begin

  task automatic t_ref();
    defaults();
    fin = 1'b1;
    r_en = 1'b1;
    r_src = SW'(5);
    div = 16'h0010;
    route = ROUTE_REF;
    pulse(start);
    wait_wr();
    // Early reference, before the pretrigger part is in
    FUNC_PIN_IN[5] = 1'b1;
    seen = 0;
    repeat (6) begin
      tick();
      if (pin_out === 1'b1) seen = 1;
    end
    check(seen == 0, "early reference reached the pin");
    FUNC_PIN_IN[5] = 1'b0;
    while (wr_cnt < 8 && k < 400) wait_wr();
    // Let the write just issued reach the count
    tick();
    n0 = wr_cnt;
    FUNC_PIN_IN[5] = 1'b1;
    repeat (6) begin
      tick();
      if (pin_out === 1'b1) seen = 1;
    end
    check(seen == 1, "reference pulse on pin");
    wait_done();
    FUNC_PIN_IN[5] = 1'b0;
    check(wr_cnt - n0 == 2, "posttrigger count");
    check(drop_cnt == n0 - int'(n_buf), "oldest dropped");
  endtask : t_ref

  task automatic t_hold();
    for (int f = 0; f < 2; f++) begin
      defaults();
      h_en = 1'b1;
      h_low = f[0];
      h_src = f[0] ? SW'(FUNC_PIN_N + 1) : SW'(3);
      FUNC_PIN_IN[3] = f[0];
      thr = f[0];
      pulse(start);
      wait_wr();
      FUNC_PIN_IN[3] = ~f[0];
      thr = ~f[0];
      tick(6);
      n0 = wr_cnt;
      tick(40);
      check(wr_cnt == n0, "strobe halted by hold level");
      FUNC_PIN_IN[3] = f[0];
      thr = f[0];
      tick(20);
      check(wr_cnt > n0, "strobe resumed");
      pulse(stop);
      wait_done();
    end
  endtask : t_hold

  task automatic t_ext();
    defaults();
    s_ext = 1'b1;
    s_fall = 1'b1;
    route = ROUTE_STROBE;
    pulse(start);
    tick(10);
    check(pin_out === 1'b1, "pin is inverted strobe low");
    EXT_STROBE = 1'b1;
    tick(10);
    check(wr_cnt == 0 && pin_out === 1'b0, "rising edge ignored");
    EXT_STROBE = 1'b0;
    tick(10);
    check(wr_cnt == 1, "falling edge sampled");
    pulse(stop);
    wait_done();
  endtask : t_ext

  task automatic t_timebase();
    defaults();
    tb_ext = 1'b1;
    div = 16'h0002;
    pulse(start);
    n0 = 0;
    k = 0;
    // External timebase rises every 10 cycles; divide by 2 gives 20
    for (int c = 0; c < 200; c++) begin
      tick();
      if (c % 5 == 0) tbase = ~tbase;
      if (wr === 1'b1) begin
        if (n0 > 0) check(c - k == 20, "external timebase spacing");
        n0++;
        k = c;
      end
    end
    check(n0 >= 9, "external timebase writes");
    pulse(stop);
    wait_done();
  endtask : t_timebase

  task automatic t_filter();
    defaults();
    filt = 1'b1;
    pulse(start);
    // Three cycles is below half of the 100 ns minimum width
    DI_LINES = 8'h5a;
    tick(3);
    DI_LINES = 8'ha5;
    n0 = 0;
    repeat (40) begin
      tick();
      if (wr === 1'b1 && wdata !== 8'ha5) n0++;
    end
    check(n0 == 0, "short pulse passed filter");
    DI_LINES = 8'h5a;
    tick(4);
    check(last === 8'ha5, "filtered line moved at once");
    tick(40);
    check(last === 8'h5a, "stable level not passed");
    pulse(stop);
    wait_done();
    DI_LINES = 8'ha5;
  endtask : t_filter

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    defaults();
    tick(3);
    RST_N = 1'b1;
    tick(4);
    t_finite();
    t_overflow();
    t_begin();
    t_ref();
    t_hold();
    t_ext();
    t_timebase();
    t_filter();
    finish_test();
  end

  // All scenarios need well under 10000 cycles
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule : di_acquisition_timing_engine_tb
